// ===== mdv_pkg.sv
package mdv_pkg;

   // -----------------------------------------------------------------
   // Register map, byte addresses on the bus.
   // -----------------------------------------------------------------
   localparam logic [7:0] DATA0_OFF  = 8'h00;
   localparam logic [7:0] DATA5_OFF  = 8'h14;
   localparam logic [7:0] STATUS_OFF = 8'h18;
   localparam int         NUM_DATA   = 6;

   // -----------------------------------------------------------------
   // Status fields and reset values.
   // -----------------------------------------------------------------
   localparam int         ERR_BIT    = 7;
   localparam int         OVF_BIT    = 6;
   localparam logic [7:0] DATA_RST   = 8'h00;
   localparam logic       FLAG_RST   = 1'h0;

   // -----------------------------------------------------------------
   // Calculation times in system clock periods.
   // -----------------------------------------------------------------
   localparam int         CNT_W      = 5;
   localparam logic [4:0] LAT_DIV32  = 5'h11;
   localparam logic [4:0] LAT_DIV16  = 5'h09;
   localparam logic [4:0] LAT_MUL    = 5'h0B;

   // -----------------------------------------------------------------
   // Result bytes written back per operation.
   // -----------------------------------------------------------------
   localparam logic [5:0] MASK_DIV32 = 6'h3F;
   localparam logic [5:0] MASK_DIV16 = 6'h33;
   localparam logic [5:0] MASK_MUL   = 6'h0F;

   typedef enum logic [1:0] {OP_DIV32, OP_DIV16, OP_MUL} mdv_op_t;

   typedef enum logic [3:0] {
      SEQ_IDLE, SEQ_0, SEQ_01, SEQ_012, SEQ_0123, SEQ_01234, SEQ_014, SEQ_04, SEQ_041
   } mdv_seq_t;

   typedef struct packed {
      logic [31:0] quo;
      logic [15:0] rem;
   } mdv_div_res_t;

   typedef struct packed {
      logic [31:0] prod;
      logic        ovf;
   } mdv_mul_res_t;

endpackage : mdv_pkg

// ===== mdv_mul.sv
`timescale 1ns/1ps
`default_nettype none

module mdv_mul
(
   // Operands
   input  wire logic [15:0]          mcand_i,
   input  wire logic [15:0]          mplier_i,
   // Result
   output var mdv_pkg::mdv_mul_res_t res_o
);

   logic [31:0] prod_w;

   // Both operands are unsigned.
   assign prod_w     = mcand_i * mplier_i;
   assign res_o.prod = prod_w;
   assign res_o.ovf  = |prod_w[31:16];

endmodule : mdv_mul

`default_nettype wire

// ===== mdv_div.sv
`timescale 1ns/1ps
`default_nettype none

module mdv_div #(
   parameter int BPS = 2
)
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   // Start
   input  wire logic                 start_i,
   input  wire logic                 wide_i,
   input  wire logic [31:0]          dividend_i,
   input  wire logic [15:0]          divisor_i,
   // Result
   output var mdv_pkg::mdv_div_res_t res_o
);

   localparam logic [5:0] STEPS_W = 6'(32 / BPS);
   localparam logic [5:0] STEPS_N = 6'(16 / BPS);

   logic [31:0] q_q;
   logic [31:0] q_d;
   logic [15:0] r_q;
   logic [15:0] r_d;
   logic [15:0] d_q;
   logic [5:0]  steps_q;

   // Restoring division, BPS quotient bits per clock.
   always_comb
   begin
      logic [16:0] t;
      t   = '0;
      q_d = q_q;
      r_d = r_q;
      for (int i = 0; i < BPS; i++)
      begin
         t   = {r_d, q_d[31]};
         q_d = {q_d[30:0], 1'b0};
         if (t >= {1'b0, d_q})
         begin
            t      = t - {1'b0, d_q};
            q_d[0] = 1'b1;
         end
         r_d = t[15:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q_q     <= '0;
         r_q     <= '0;
         d_q     <= '0;
         steps_q <= '0;
      end
      else if (ce_i)
      begin
         if (start_i)
         begin
            q_q     <= wide_i ? dividend_i : {dividend_i[15:0], 16'h0000};
            r_q     <= '0;
            d_q     <= divisor_i;
            steps_q <= wide_i ? STEPS_W : STEPS_N;
         end
         else if (steps_q != 6'h00)
         begin
            q_q     <= q_d;
            r_q     <= r_d;
            steps_q <= steps_q - 6'h01;
         end
      end
   end

   assign res_o.quo = q_q;
   assign res_o.rem = r_q;

endmodule : mdv_div

`default_nettype wire

// ===== mdv_top.sv
//
// Contract
// - Writes to data registers 0 to 5 in order select 32 by 16 division.
// - Writes to registers 0, 1, 4, 5 in order select 16 by 16 division.
// - Writes to registers 0, 4, 1, 5 in order select 16 by 16 multiplication.
// - A calculation starts only on a register 5 write closing a valid order.
// - Non-writes between operand writes leave the order tracking untouched.
// - Calculation takes 17, 9 or 11 clocks for the three operations.
// - Any data register access during a calculation sets the access error flag.
// - Reading status after the calculation clears a set access error flag.
// - Overflow flags a product above FFFF or a zero divisor.
// - Each finished calculation rewrites overflow with its own outcome only.
// - Status bits 5 to 0 always read zero.
// - After 32 by 16 division, quotient sits in bytes 0 to 3, remainder 4, 5.
// - After 16 by 16 division, quotient sits in bytes 0, 1, remainder 4, 5.
// - After multiplication, the product sits in bytes 0 to 3, low byte first.
// - Reads, status writes and writes during a calculation between result reads do not disturb results; data writes while idle overwrite them.
// - The multiplier treats both operands as unsigned.
//
`timescale 1ns/1ps
`default_nettype none

module mdv_top
(
   // Clock, reset and clock enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Status
   output logic             calc_busy_o
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0]              regs_q [mdv_pkg::NUM_DATA];
   mdv_pkg::mdv_seq_t       seq_q;
   mdv_pkg::mdv_seq_t       seq_d;
   mdv_pkg::mdv_op_t        op_q;
   mdv_pkg::mdv_op_t        op_d;
   logic                    start_d;
   logic                    busy_q;
   logic [mdv_pkg::CNT_W-1:0] cnt_q;
   logic                    err_q;
   logic                    ovf_q;
   mdv_pkg::mdv_div_res_t   div_res;
   mdv_pkg::mdv_mul_res_t   mul_res;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire        setup_w    = psel_i & ~penable_i;
   wire        access_w   = psel_i & penable_i & pready_o;
   wire        data_hit_w = (paddr_i >= mdv_pkg::DATA0_OFF) & (paddr_i <= mdv_pkg::DATA5_OFF)
                            & (paddr_i[1:0] == 2'h0);
   wire        stat_hit_w = (paddr_i == mdv_pkg::STATUS_OFF);
   wire [7:0]  rel_w      = paddr_i - mdv_pkg::DATA0_OFF;
   wire [2:0]  idx_w      = rel_w[4:2];
   wire        dwr_w      = access_w & pwrite_i & data_hit_w;
   wire        drd_w      = access_w & ~pwrite_i & data_hit_w;
   wire        srd_w      = access_w & ~pwrite_i & stat_hit_w;
   wire        store_w    = dwr_w & ~busy_q;
   wire [7:0]  status_w   = {err_q, ovf_q, 6'h00};
   wire [7:0]  rbyte_w    = stat_hit_w ? status_w
                          : data_hit_w ? regs_q[idx_w] : 8'h00;
   wire        unmapped_w = ~data_hit_w & ~stat_hit_w;

   // ---------------------------------------------------------------
   // Operands and results
   // ---------------------------------------------------------------
   wire [15:0] mcand_w    = {regs_q[1], regs_q[0]};
   wire [15:0] mplier_w   = {regs_q[5], regs_q[4]};
   wire [31:0] dvd_w      = {regs_q[3], regs_q[2], regs_q[1], regs_q[0]};
   wire [15:0] dvs_w      = {pwdata_i[7:0], regs_q[4]};
   wire        done_w     = busy_q & (cnt_q == 5'h01);
   wire        is_mul_w   = (op_q == mdv_pkg::OP_MUL);
   wire        ovf_w      = is_mul_w ? mul_res.ovf : (mplier_w == 16'h0000);
   wire [47:0] res_w      = is_mul_w ? {16'h0000, mul_res.prod}
                                     : {div_res.rem, div_res.quo};
   wire [5:0]  mask_w     = (op_q == mdv_pkg::OP_DIV32) ? mdv_pkg::MASK_DIV32
                          : (op_q == mdv_pkg::OP_DIV16) ? mdv_pkg::MASK_DIV16
                          : mdv_pkg::MASK_MUL;
   wire [4:0]  lat_w      = (op_d == mdv_pkg::OP_DIV32) ? mdv_pkg::LAT_DIV32
                          : (op_d == mdv_pkg::OP_DIV16) ? mdv_pkg::LAT_DIV16
                          : mdv_pkg::LAT_MUL;
   wire        err_set_w  = (dwr_w | drd_w) & busy_q;
   wire        err_clr_w  = srd_w & ~busy_q & err_q;

   // ---------------------------------------------------------------
   // Arithmetic units
   // ---------------------------------------------------------------
   mdv_mul u_mul
   (
      .mcand_i    (mcand_w),
      .mplier_i   (mplier_w),
      .res_o      (mul_res)
   );

   mdv_div #(
      .BPS        (2)
   ) u_div
   (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .start_i    (start_d),
      .wide_i     (op_d == mdv_pkg::OP_DIV32),
      .dividend_i (dvd_w),
      .divisor_i  (dvs_w),
      .res_o      (div_res)
   );

   // ---------------------------------------------------------------
   // Write order tracking
   // ---------------------------------------------------------------
   always_comb
   begin
      seq_d   = seq_q;
      op_d    = mdv_pkg::OP_MUL;
      start_d = 1'b0;
      if (store_w)
      begin
         seq_d = (idx_w == 3'h0) ? mdv_pkg::SEQ_0 : mdv_pkg::SEQ_IDLE;
         case (seq_q)
            mdv_pkg::SEQ_0:
            begin
               if (idx_w == 3'h1)
                  seq_d = mdv_pkg::SEQ_01;
               else if (idx_w == 3'h4)
                  seq_d = mdv_pkg::SEQ_04;
            end
            mdv_pkg::SEQ_01:
            begin
               if (idx_w == 3'h2)
                  seq_d = mdv_pkg::SEQ_012;
               else if (idx_w == 3'h4)
                  seq_d = mdv_pkg::SEQ_014;
            end
            mdv_pkg::SEQ_012:
            begin
               if (idx_w == 3'h3)
                  seq_d = mdv_pkg::SEQ_0123;
            end
            mdv_pkg::SEQ_0123:
            begin
               if (idx_w == 3'h4)
                  seq_d = mdv_pkg::SEQ_01234;
            end
            mdv_pkg::SEQ_01234:
            begin
               if (idx_w == 3'h5)
               begin
                  start_d = 1'b1;
                  op_d    = mdv_pkg::OP_DIV32;
               end
            end
            mdv_pkg::SEQ_014:
            begin
               if (idx_w == 3'h5)
               begin
                  start_d = 1'b1;
                  op_d    = mdv_pkg::OP_DIV16;
               end
            end
            mdv_pkg::SEQ_04:
            begin
               if (idx_w == 3'h1)
                  seq_d = mdv_pkg::SEQ_041;
            end
            mdv_pkg::SEQ_041:
            begin
               if (idx_w == 3'h5)
               begin
                  start_d = 1'b1;
                  op_d    = mdv_pkg::OP_MUL;
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Bus answer, no wait states
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= '0;
      end
      else if (ce_i)
      begin
         pready_o  <= setup_w;
         pslverr_o <= setup_w & unmapped_w;
         if (setup_w)
            prdata_o <= {24'h000000, rbyte_w};
      end
   end

   // ---------------------------------------------------------------
   // Calculation control
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         seq_q       <= mdv_pkg::SEQ_IDLE;
         op_q        <= mdv_pkg::OP_MUL;
         busy_q      <= 1'b0;
         calc_busy_o <= 1'b0;
         cnt_q       <= '0;
      end
      else if (ce_i)
      begin
         seq_q <= seq_d;
         if (start_d)
         begin
            op_q        <= op_d;
            busy_q      <= 1'b1;
            calc_busy_o <= 1'b1;
            cnt_q       <= lat_w;
         end
         else if (busy_q)
         begin
            cnt_q <= cnt_q - 5'h01;
            if (done_w)
            begin
               busy_q      <= 1'b0;
               calc_busy_o <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Status flags
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_q <= mdv_pkg::FLAG_RST;
         ovf_q <= mdv_pkg::FLAG_RST;
      end
      else if (ce_i)
      begin
         if (err_set_w)
            err_q <= 1'b1;
         else if (err_clr_w)
            err_q <= 1'b0;
         if (done_w)
            ovf_q <= ovf_w;
      end
   end

   // ---------------------------------------------------------------
   // Operand and result bytes
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < mdv_pkg::NUM_DATA; i++)
            regs_q[i] <= mdv_pkg::DATA_RST;
      end
      else if (ce_i)
      begin
         for (int i = 0; i < mdv_pkg::NUM_DATA; i++)
         begin
            if (done_w && mask_w[i])
               regs_q[i] <= res_w[8*i +: 8];
            else if (store_w && (idx_w == 3'(i)))
               regs_q[i] <= pwdata_i[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (rst_i || !ce_i);

   a_start_on_last: assert property (
      start_d |-> store_w && idx_w == 3'h5 && seq_q inside {mdv_pkg::SEQ_01234,
                  mdv_pkg::SEQ_014, mdv_pkg::SEQ_041})
      else $error("start without a complete write order");

   a_div32_time: assert property (
      start_d && op_d == mdv_pkg::OP_DIV32 |=> busy_q ##17 !busy_q)
      else $error("wide division time is not 17 clocks");

   a_div16_time: assert property (
      start_d && op_d == mdv_pkg::OP_DIV16 |=> busy_q ##9 !busy_q)
      else $error("narrow division time is not 9 clocks");

   a_mul_time: assert property (
      start_d && op_d == mdv_pkg::OP_MUL |=> busy_q ##11 !busy_q)
      else $error("multiplication time is not 11 clocks");

   a_err_on_busy: assert property (
      (dwr_w || drd_w) && busy_q |=> err_q)
      else $error("access during calculation did not set error");

   a_err_clear_read: assert property (
      srd_w && !busy_q && !err_set_w |=> !err_q)
      else $error("status read did not clear error");

   a_err_holds_busy: assert property (
      err_q && busy_q |=> err_q)
      else $error("error flag cleared during calculation");

   a_ovf_zero_div: assert property (
      done_w && !is_mul_w && mplier_w == 16'h0000 |=> ovf_q)
      else $error("zero divisor not flagged");

   a_ovf_per_calc: assert property (
      done_w |=> ovf_q == $past(ovf_w))
      else $error("overflow not rewritten at calculation end");

   a_status_low_zero: assert property (
      pready_o && psel_i && stat_hit_w && !pwrite_i |-> prdata_o[5:0] == 6'h00)
      else $error("unused status bits not zero");

   a_mul_product: assert property (
      done_w && is_mul_w |=> {regs_q[3], regs_q[2], regs_q[1], regs_q[0]}
                             == $past(mcand_w) * $past(mplier_w))
      else $error("product bytes wrong");

   a_div_remainder: assert property (
      done_w && op_q == mdv_pkg::OP_DIV32 && mplier_w != 16'h0000
      |=> {regs_q[5], regs_q[4]} == $past(dvd_w) % $past(mplier_w))
      else $error("remainder bytes wrong");

   a_regs_stable: assert property (
      !busy_q && !store_w |=> regs_q[0] == $past(regs_q[0]))
      else $error("result byte changed without cause");

   c_div32: cover property (start_d && op_d == mdv_pkg::OP_DIV32);
   c_div16: cover property (start_d && op_d == mdv_pkg::OP_DIV16);
   c_mul:   cover property (start_d && op_d == mdv_pkg::OP_MUL);
   c_err:   cover property (err_set_w);

endmodule : mdv_top

`default_nettype wire

// ===== test_multiply_divide_unit.sv
`timescale 1ns/1ps
`default_nettype none

module test_multiply_divide_unit;

   // ------------------------------------------------------------
   // Signals and counters.
   // ------------------------------------------------------------
   logic        clk_i      = 1'b0;
   logic        rst_i      = 1'b1;
   logic        ce_i       = 1'b1;
   logic        psel_i     = 1'b0;
   logic        penable_i  = 1'b0;
   logic        pwrite_i   = 1'b0;
   logic [7:0]  paddr_i    = 8'h00;
   logic [31:0] pwdata_i   = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic        calc_busy_o;
   logic        slv_err;
   logic [31:0] rd;
   int          n_errors   = 0;
   int          n_compared = 0;
   int          ops[6]     = '{2, 2, 1, 0, 1, 0};
   logic [31:0] xs[6]      = '{32'h0000_FFFF, 32'h0000_00F0, 32'h0000_1234,
                               32'h1234_5678, 32'h0000_1234, 32'hFFFF_FFFF};
   logic [15:0] ys[6]      = '{16'hFFFF, 16'h0101, 16'h0056, 16'h1234, 16'h0000, 16'h0001};

   always #2.5 clk_i = ~clk_i;

   mdv_top dut_u (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .psel_i      (psel_i),
      .penable_i   (penable_i),
      .pwrite_i    (pwrite_i),
      .paddr_i     (paddr_i),
      .pwdata_i    (pwdata_i),
      .prdata_o    (prdata_o),
      .pready_o    (pready_o),
      .pslverr_o   (pslverr_o),
      .calc_busy_o (calc_busy_o)
   );

   // ------------------------------------------------------------
   // Bus and checking tasks.
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [7:0] ra(input int i);
      return mdv_pkg::DATA0_OFF + 8'(4 * i);
   endfunction : ra

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= {24'h00_0000, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      do
      begin
         @(posedge clk_i);
      end
      while (pready_o !== 1'b1);
      rd        = prdata_o;
      slv_err   = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : xfer

   task automatic rstat(input logic [31:0] e);
      xfer(1'b0, mdv_pkg::STATUS_OFF, 8'h00);
      chk(rd, e);
   endtask : rstat

   task automatic wait_busy(input int exp);
      int n;
      n = 0;
      #1;
      while (calc_busy_o === 1'b1 && n < 40)
      begin
         n++;
         @(posedge clk_i);
         #1;
      end
      if (exp >= 0)
         chk(32'(n), 32'(exp));
   endtask : wait_busy

   task automatic load(input int op, input logic [31:0] x, input logic [15:0] y);
      logic [47:0] w;
      int          ord[$];
      w = (op == 0) ? {y, x} : {y, 16'h0000, x[15:0]};
      if (op == 0)
         ord = '{0, 1, 2, 3, 4, 5};
      else if (op == 1)
         ord = '{0, 1, 4, 5};
      else
         ord = '{0, 4, 1, 5};
      foreach (ord[k])
      begin
         xfer(1'b1, ra(ord[k]), w[8 * ord[k] +: 8]);
         if (k == 1)
            xfer(1'b0, ra(2), 8'h00);
      end
   endtask : load

   task automatic check_res(input int op, input logic [31:0] x, input logic [15:0] y,
                            input logic err);
      logic [47:0] v;
      logic [31:0] q;
      logic [15:0] r;
      logic        ovf;
      int          ord[$];
      if (op == 2)
      begin
         q   = 32'(x[15:0]) * 32'(y);
         ovf = (q > 32'h0000_FFFF);
         v   = {16'h0000, q};
         ord = '{0, 1, 2, 3};
      end
      else
      begin
         ovf = (y == 16'h0000);
         q   = ovf ? 32'hFFFF_FFFF : (op == 0 ? x / 32'(y) : 32'(x[15:0] / y));
         r   = ovf ? 16'h0000 : (op == 0 ? 16'(x % 32'(y)) : x[15:0] % y);
         v   = {r, (op == 0) ? q[31:16] : 16'h0000, q[15:0]};
         if (op == 0)
            ord = '{0, 1, 2, 3, 4, 5};
         else
            ord = '{0, 1, 4, 5};
         if (ovf)
            repeat (2) void'(ord.pop_back());
      end
      rstat({24'h00_0000, err, ovf, 6'h00});
      foreach (ord[k])
      begin
         xfer(1'b0, ra(ord[k]), 8'h00);
         chk(rd, {24'h00_0000, v[8 * ord[k] +: 8]});
         if (k == 0)
            rstat({24'h00_0000, 1'b0, ovf, 6'h00});
      end
   endtask : check_res

   task automatic no_start(input int seq[$]);
      foreach (seq[k])
         xfer(1'b1, ra(seq[k]), 8'h01);
      repeat (3)
      begin
         @(posedge clk_i);
         #1;
         chk({31'h0, calc_busy_o}, 32'h0);
      end
   endtask : no_start

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : results

   // ------------------------------------------------------------
   // Test sequence.
   // ------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rstat(32'h0000_0000);
      xfer(1'b1, mdv_pkg::STATUS_OFF, 8'hFF);
      rstat(32'h0000_0000);
      xfer(1'b0, 8'h1C, 8'h00);
      chk({31'h0, slv_err}, 32'h1);
      for (int i = 0; i < 6; i++)
      begin
         load(ops[i], xs[i], ys[i]);
         wait_busy(ops[i] == 0 ? 17 : (ops[i] == 1 ? 9 : 11));
         check_res(ops[i], xs[i], ys[i], 1'b0);
      end
      no_start('{0, 1, 2, 5});
      no_start('{0, 4, 5});
      no_start('{5});
      no_start('{0, 1, 2});
      load(1, 32'h0000_0100, 16'h0003);
      wait_busy(9);
      check_res(1, 32'h0000_0100, 16'h0003, 1'b0);
      load(1, 32'h0000_FFFF, 16'h00FF);
      @(posedge clk_i);
      ce_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      ce_i <= 1'b1;
      wait_busy(8);
      check_res(1, 32'h0000_FFFF, 16'h00FF, 1'b0);
      load(2, 32'h0000_1234, 16'h5678);
      xfer(1'b1, ra(3), 8'hAA);
      xfer(1'b0, mdv_pkg::STATUS_OFF, 8'h00);
      chk(rd & 32'h0000_00BF, 32'h0000_0080);
      wait_busy(-1);
      check_res(2, 32'h0000_1234, 16'h5678, 1'b1);
      load(1, 32'h0000_0064, 16'h0007);
      xfer(1'b0, ra(0), 8'h00);
      wait_busy(-1);
      check_res(1, 32'h0000_0064, 16'h0007, 1'b1);
      results();
   end

   initial
   begin
      #(5 * 20000);
      n_errors++;
      results();
   end

endmodule : test_multiply_divide_unit

`default_nettype wire
